// file: design/anp_pkg.sv
package anp_pkg;

    // Bus geometry.
    localparam int          ADDR_W          = 14;
    localparam int          DATA_W          = 32;
    localparam int          IDX_W           = 12;
    localparam int          IDX_LSB         = 2;
    localparam int          STRB_W          = 4;

    // Word indices of the registers; the byte address is four times the index.
    localparam logic [11:0] IDX_UNP_UPPER   = 12'h04c6;
    localparam logic [11:0] IDX_PBP_LOWER   = 12'h04c7;
    localparam logic [11:0] IDX_PBP_UPPER   = 12'h04c8;
    localparam logic [11:0] IDX_PNP_LOWER   = 12'h04c9;
    localparam logic [11:0] IDX_PNP_UPPER   = 12'h04ca;
    localparam logic [11:0] IDX_PADV        = 12'h04cb;

    // Reset values.
    localparam logic [31:0] UNP_UPPER_RST   = 32'h0000_0000;
    localparam logic [47:0] PAGE_RST        = 48'h0000_0000_0000;
    localparam logic [49:0] TX_PAGE_RST     = 50'h0_0000_0000_0000;

    // AXI responses.
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Page layout.
    localparam int          PAGE_W          = 48;
    localparam int          TX_PAGE_W       = 50;
    localparam int          LOW_W           = 16;
    localparam int          UPPER_LSB       = 16;
    localparam int          UPPER_MSB       = 47;
    localparam int          PSEUDO_RANDOM_PAGE_BIT_BIT        = 49;
    localparam int          SPARE_BIT       = 48;
    localparam int          TECH_LSB        = 21;
    localparam int          TECH_MSB        = 45;
    localparam int          TECH_W          = 25;
    localparam int          NONCE_LSB       = 16;
    localparam int          NONCE_MSB       = 20;
    localparam int          FEC_ABLE_BIT    = 46;
    localparam int          FEC_REQ_BIT     = 47;
    localparam int          FAULT_BIT       = 13;
    localparam int          TECH_KX_BIT     = 0;
    localparam int          TECH_KR_BIT     = 2;
    localparam int          NP_BIT          = 15;
    localparam int          ACK_BIT         = 14;
    localparam int          MSG_PAGE_BIT    = 13;
    localparam int          SECOND_ACKNOWLEDGE_BIT        = 12;
    localparam int          TOGGLE_BIT      = 11;

    // Pseudo-random generator.
    localparam int          LFSR_W          = 11;
    localparam logic [10:0] LFSR_SEED       = 11'h7ff;
    localparam int          LFSR_TAP_A      = 10;
    localparam int          LFSR_TAP_B      = 8;

endpackage

// file: design/anp_tx_page.sv
`timescale 1ns/1ns
module anp_tx_page
    import anp_pkg::*;
(
    // Clock and reset.
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    // Page request from the transmit state machine.
    input  wire logic                         tx_page_req,
    input  wire logic                         tx_np_select,
    input  wire logic [anp_pkg::PAGE_W-1:0]   tx_base_page,
    input  wire logic [anp_pkg::LOW_W-1:0]    tx_np_lower,
    input  wire logic [anp_pkg::DATA_W-1:0]   unp_upper,
    // Assembled page.
    output logic      [anp_pkg::TX_PAGE_W-1:0] tx_page
);
    import anp_pkg::*;

    logic [LFSR_W-1:0]    lfsr_r;
    logic [TX_PAGE_W-1:0] page_r;

    // A free-running generator steps every cycle, so the bit taken depends on when the request comes.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            lfsr_r <= LFSR_SEED;
        else
            lfsr_r <= {lfsr_r[LFSR_W-2:0], lfsr_r[LFSR_TAP_A] ^ lfsr_r[LFSR_TAP_B]};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            page_r <= TX_PAGE_RST;
        else if (tx_page_req)
        begin
            page_r[PSEUDO_RANDOM_PAGE_BIT_BIT]  <= lfsr_r[0];
            page_r[SPARE_BIT] <= 1'b0;
            if (tx_np_select)
                page_r[PAGE_W-1:0] <= {unp_upper, tx_np_lower};
            else
                page_r[PAGE_W-1:0] <= tx_base_page;
        end
    end

    assign tx_page = page_r;

    a_pseudo_random_page_bit_own_source: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_page_req |=> tx_page[PSEUDO_RANDOM_PAGE_BIT_BIT] == $past(lfsr_r[0]))
        else $error("page bit 49 not taken from the generator");

endmodule

// file: design/anp_rx_capture.sv
`timescale 1ns/1ns
module anp_rx_capture
    import anp_pkg::*;
(
    // Clock and reset.
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // Accepted page from the receive state machine.
    input  wire logic                        rx_page_valid,
    input  wire logic                        rx_page_is_next,
    input  wire logic [anp_pkg::PAGE_W-1:0]  rx_page,
    // Held pages.
    output logic      [anp_pkg::PAGE_W-1:0]  base_page,
    output logic      [anp_pkg::PAGE_W-1:0]  next_page
);
    import anp_pkg::*;

    logic [PAGE_W-1:0] base_r;
    logic [PAGE_W-1:0] next_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            base_r <= PAGE_RST;
        else if (rx_page_valid && !rx_page_is_next)
            base_r <= rx_page;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            next_r <= PAGE_RST;
        else if (rx_page_valid && rx_page_is_next)
            next_r <= rx_page;
    end

    assign base_page = base_r;
    assign next_page = next_r;

    a_page_held_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !rx_page_valid |=> $stable(base_r) && $stable(next_r))
        else $error("partner page changed without an accepted page");

endmodule

// file: design/anp_top.sv
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
// Summary of operation
// - With next-page selection on, transmitted page bits 47 to 16 come straight from the user next-page upper word.
// - Page bit 49 is made by an internal pseudo-random generator, never by a software register.
// - Partner base lower reads next page, acknowledge, fault, pause, echoed nonce and selector at bits 15 down to 0.
// - Partner base upper reads ability bits 45:21 at 29:5 and nonce bits 20:16 at 4:0 with 31:30 zero.
// - Partner next lower reads next page, acknowledge, message page, second acknowledge and toggle at bits 15 to 11.
// - Partner next upper reads received next-page bits 47 to 16 at bits 31 to 0.
// - The partner technology field of 25 bits reads at bits 24:0 of the advertised abilities word.
// - Only ability bits 0 and 2 of the partner drive the block's own outputs.
// - The partner FEC ability and request, from page bits 46 and 47, read at bits 25 and 26.
// - The partner fault indication, from page bit 13, reads at bit 27.
module anp_top
    import anp_pkg::*;
(
    // Clock and reset.
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // AXI4-Lite write address.
    input  wire logic [anp_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    // AXI4-Lite write data.
    input  wire logic [anp_pkg::DATA_W-1:0]    s_axi_wdata,
    input  wire logic [anp_pkg::STRB_W-1:0]    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    // AXI4-Lite write response.
    output logic      [1:0]                    s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // AXI4-Lite read address.
    input  wire logic [anp_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    // AXI4-Lite read data.
    output logic      [anp_pkg::DATA_W-1:0]    s_axi_rdata,
    output logic      [1:0]                    s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Transmit state machine side.
    input  wire logic                          tx_page_req,
    input  wire logic                          tx_np_select,
    input  wire logic [anp_pkg::PAGE_W-1:0]    tx_base_page,
    input  wire logic [anp_pkg::LOW_W-1:0]     tx_np_lower,
    output logic      [anp_pkg::TX_PAGE_W-1:0] tx_page,
    // Receive state machine side.
    input  wire logic                          rx_page_valid,
    input  wire logic                          rx_page_is_next,
    input  wire logic [anp_pkg::PAGE_W-1:0]    rx_page,
    // Partner abilities acted on by the single-lane layer.
    output logic                               partner_kx_able,
    output logic                               partner_kr_able
);
    import anp_pkg::*;

    function automatic logic [IDX_W-1:0] anp_index(input logic [ADDR_W-1:0] addr);
        anp_index = addr[ADDR_W-1:IDX_LSB];
    endfunction

    function automatic logic anp_mapped(input logic [IDX_W-1:0] idx);
        anp_mapped = (idx >= IDX_UNP_UPPER) && (idx <= IDX_PADV);
    endfunction

    logic [DATA_W-1:0] unp_upper_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic [PAGE_W-1:0] base_page;
    logic [PAGE_W-1:0] next_page;
    logic [TECH_W-1:0] partner_technology_field;
    logic [1:0]        partner_fec_field;
    logic              partner_fault_flag;
    logic              wr_fire;
    logic              rd_fire;
    logic [IDX_W-1:0]  wr_idx;
    logic [IDX_W-1:0]  rd_idx;

    // Address and data are taken in the same edge; this keeps the slave free of
    // half-accepted writes at the cost of one channel waiting for the other.
    assign wr_idx        = anp_index(s_axi_awaddr);
    assign rd_idx        = anp_index(s_axi_araddr);
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign s_axi_wready  = s_axi_awready;
    assign wr_fire       = s_axi_awready;
    assign s_axi_arready = !rvalid_r;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            unp_upper_r <= UNP_UPPER_RST;
        else if (wr_fire && wr_idx == IDX_UNP_UPPER)
        begin
            for (int b = 0; b < STRB_W; b++)
            begin
                if (s_axi_wstrb[b])
                    unp_upper_r[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_r <= 1'b1;
            bresp_r  <= anp_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_r <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    // Partner ability fields decoded from the held base page.
    assign partner_technology_field = base_page[TECH_MSB:TECH_LSB];
    assign partner_fec_field        = {base_page[FEC_REQ_BIT], base_page[FEC_ABLE_BIT]};
    assign partner_fault_flag       = base_page[FAULT_BIT];

    // The other ability bits name rates this layer cannot run, so they stay software-only.
    assign partner_kx_able = partner_technology_field[TECH_KX_BIT];
    assign partner_kr_able = partner_technology_field[TECH_KR_BIT];

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        case (rd_idx)
            IDX_UNP_UPPER:
                rdata_nxt = unp_upper_r;
            IDX_PBP_LOWER:
                rdata_nxt = {16'h0000, base_page[LOW_W-1:0]};
            IDX_PBP_UPPER:
                rdata_nxt = {2'h0, base_page[TECH_MSB:TECH_LSB],
                             base_page[NONCE_MSB:NONCE_LSB]};
            IDX_PNP_LOWER:
                rdata_nxt = {16'h0000, next_page[LOW_W-1:0]};
            IDX_PNP_UPPER:
                rdata_nxt = next_page[UPPER_MSB:UPPER_LSB];
            IDX_PADV:
                rdata_nxt = {4'h0, partner_fault_flag, partner_fec_field,
                             partner_technology_field};
            default:
                rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end
        else if (rd_fire)
        begin
            rvalid_r <= 1'b1;
            rresp_r  <= anp_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
            rdata_r  <= rdata_nxt;
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp  = rresp_r;
    assign s_axi_rdata  = rdata_r;

    anp_tx_page u_tx_page
    (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .tx_page_req  (tx_page_req),
        .tx_np_select (tx_np_select),
        .tx_base_page (tx_base_page),
        .tx_np_lower  (tx_np_lower),
        .unp_upper    (unp_upper_r),
        .tx_page      (tx_page)
    );

    anp_rx_capture u_rx_capture
    (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .rx_page_valid   (rx_page_valid),
        .rx_page_is_next (rx_page_is_next),
        .rx_page         (rx_page),
        .base_page       (base_page),
        .next_page       (next_page)
    );

    a_np_upper_map: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_page_req && tx_np_select |=> tx_page[UPPER_MSB:UPPER_LSB] == $past(unp_upper_r))
        else $error("transmitted next page upper bits differ from the user word");

    a_pseudo_random_page_bit_not_sw: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && !tx_page_req |=> $stable(tx_page[PSEUDO_RANDOM_PAGE_BIT_BIT]))
        else $error("page bit 49 followed a register write");

    a_base_low_read: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == IDX_PBP_LOWER
        |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(base_page[LOW_W-1:0])})
        else $error("partner base lower read wrong");

    a_base_up_read: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == IDX_PBP_UPPER
        |=> s_axi_rdata[31:30] == 2'h0
            && s_axi_rdata[29:5] == $past(base_page[TECH_MSB:TECH_LSB])
            && s_axi_rdata[4:0] == $past(base_page[NONCE_MSB:NONCE_LSB]))
        else $error("partner base upper read wrong");

    a_next_low_read: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == IDX_PNP_LOWER
        |=> s_axi_rdata[MSG_PAGE_BIT] == $past(next_page[MSG_PAGE_BIT])
            && s_axi_rdata[SECOND_ACKNOWLEDGE_BIT] == $past(next_page[SECOND_ACKNOWLEDGE_BIT])
            && s_axi_rdata[TOGGLE_BIT] == $past(next_page[TOGGLE_BIT])
            && s_axi_rdata[NP_BIT:ACK_BIT] == $past(next_page[NP_BIT:ACK_BIT])
            && s_axi_rdata[31:16] == 16'h0000)
        else $error("partner next lower read wrong");

    a_next_up_read: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == IDX_PNP_UPPER
        |=> s_axi_rdata == $past(next_page[UPPER_MSB:UPPER_LSB]))
        else $error("partner next upper read wrong");

    a_tech_field_read: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == IDX_PADV
        |=> s_axi_rdata[24:0] == $past(base_page[TECH_MSB:TECH_LSB])
            && s_axi_rdata[31:28] == 4'h0)
        else $error("partner technology field read wrong");

    a_kr_kx_out: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_page_valid && !rx_page_is_next
        |=> partner_kx_able == $past(rx_page[TECH_LSB])
            && partner_kr_able == $past(rx_page[TECH_LSB + TECH_KR_BIT]))
        else $error("single-lane ability outputs wrong");

    a_fec_field_read: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == IDX_PADV
        |=> s_axi_rdata[25] == $past(base_page[FEC_ABLE_BIT])
            && s_axi_rdata[26] == $past(base_page[FEC_REQ_BIT]))
        else $error("partner FEC bits read wrong");

    a_fault_read: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == IDX_PADV
        |=> s_axi_rdata[27] == $past(base_page[FAULT_BIT]))
        else $error("partner fault bit read wrong");

    a_page_capture: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_page_valid && rx_page_is_next
        |=> next_page == $past(rx_page) ##1 ($past(rx_page_valid) || $stable(next_page)))
        else $error("partner next page not captured or not held");

    a_bus_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire |=> s_axi_bvalid && !s_axi_awready)
        else $error("write response missing one cycle after the handshake");

    a_bvalid_clear: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid)
        else $error("write answer not retired");

    a_rvalid_clear: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid)
        else $error("read answer not retired");

    a_read_answer: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_fire
        |=> s_axi_rvalid
            && !s_axi_arready)
        else $error("read answer missing");

    a_bad_read_idx: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_fire && !anp_mapped(rd_idx)
        |=> s_axi_rresp == RESP_SLVERR
            && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read answered");

    a_bad_write_idx: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && !anp_mapped(wr_idx)
        |=> s_axi_bresp == RESP_SLVERR
            && $stable(unp_upper_r))
        else $error("unmapped write answered");

    a_good_write_ok: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && anp_mapped(wr_idx)
        |=> s_axi_bvalid
            && s_axi_bresp == RESP_OKAY)
        else $error("mapped write refused");

    a_user_word_read: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_idx == IDX_UNP_UPPER
        |=> s_axi_rresp == RESP_OKAY
            && s_axi_rdata == $past(unp_upper_r))
        else $error("user word read wrong");

    a_ability_held: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !rx_page_valid || rx_page_is_next
        |=> $stable(partner_kx_able)
            && $stable(partner_kr_able))
        else $error("ability outputs moved");

    a_base_kept: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rx_page_valid && rx_page_is_next
        |=> $stable(base_page))
        else $error("base page lost to a next page");

    a_next_kept: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rx_page_valid && !rx_page_is_next
        |=> $stable(next_page)
            && base_page == $past(rx_page))
        else $error("base page capture wrong");

    a_tx_page_held: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !tx_page_req
        |=> $stable(tx_page))
        else $error("sent page moved");

    a_base_page_sent: assert property (
        @(posedge aclk) disable iff (!aresetn)
        tx_page_req && !tx_np_select
        |=> tx_page[PAGE_W-1:0] == $past(tx_base_page)
            && !tx_page[SPARE_BIT])
        else $error("base page not sent");

    a_strobe_lane: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && !s_axi_wstrb[0]
        |=> $stable(unp_upper_r[7:0]))
        else $error("disabled byte lane written");

endmodule

// file: tb/anp_rx_model.sv
`timescale 1ns/1ns
module anp_rx_model
(
    // Clock.
    input  wire logic                       aclk,
    // Accepted page toward the block.
    output logic                            rx_page_valid,
    output logic                            rx_page_is_next,
    output logic      [anp_pkg::PAGE_W-1:0] rx_page
);
    import anp_pkg::*;

    initial
    begin
        rx_page_valid   = 1'b0;
        rx_page_is_next = 1'b0;
        rx_page         = '0;
    end

    // Outside the accept cycle the lines carry the inverse, so a late sample shows up as wrong data.
    task automatic send_page(input logic is_next, input logic [PAGE_W-1:0] page);
        @(posedge aclk);
        rx_page_valid   <= 1'b1;
        rx_page_is_next <= is_next;
        rx_page         <= page;
        @(posedge aclk);
        rx_page_valid   <= 1'b0;
        rx_page_is_next <= ~is_next;
        rx_page         <= ~page;
    endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("BAD %0t got %0h want %0h", $time, g, e); end end
module testbench;
    import anp_pkg::*;

    localparam logic [47:0] PATS [3] = '{48'hffff_ffff_ffff, 48'h5a3c_9661_0d4b,
                                          48'h8000_0080_2000};
    logic              aclk;
    logic              aresetn;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [STRB_W-1:0] s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready;
    logic              tx_page_req, tx_np_select, rx_page_valid, rx_page_is_next;
    logic [PAGE_W-1:0] tx_base_page, rx_page;
    logic [LOW_W-1:0]  tx_np_lower;
    logic [49:0]       tx_page;
    logic              partner_kx_able, partner_kr_able;
    int                fails = 0;
    int                tests_run = 0;

    anp_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .tx_page_req(tx_page_req), .tx_np_select(tx_np_select),
        .tx_base_page(tx_base_page), .tx_np_lower(tx_np_lower), .tx_page(tx_page),
        .rx_page_valid(rx_page_valid), .rx_page_is_next(rx_page_is_next), .rx_page(rx_page),
        .partner_kx_able(partner_kx_able), .partner_kr_able(partner_kr_able));

    anp_rx_model rx_m (.aclk(aclk), .rx_page_valid(rx_page_valid),
        .rx_page_is_next(rx_page_is_next), .rx_page(rx_page));

    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic test_done();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic hang();
        fails++;
        $display("BAD %0t bus wait ran out", $time);
        test_done();
    endtask

    task automatic axi_write(input logic [11:0] idx, input logic [31:0] d,
                             input logic [3:0] s, input logic [1:0] er);
        int   i;
        logic aw_open;
        logic w_open;
        logic got;
        @(posedge aclk);
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        aw_open = 1'b1;
        w_open  = 1'b1;
        got     = 1'b0;
        for (i = 0; i < 50 && (aw_open || w_open); i++)
        begin
            @(posedge aclk);
            if (aw_open && s_axi_awready === 1'b1)
            begin
                s_axi_awvalid <= 1'b0;
                aw_open = 1'b0;
            end
            if (w_open && s_axi_wready === 1'b1)
            begin
                s_axi_wvalid <= 1'b0;
                w_open = 1'b0;
            end
        end
        if (aw_open || w_open)
            hang();
        for (i = 0; i < 50 && !got; i++)
        begin
            @(posedge aclk);
            if (s_axi_bvalid === 1'b1)
            begin
                got = 1'b1;
                s_axi_bready <= 1'b0;
                `CHK(s_axi_bresp, er)
            end
        end
        if (!got)
            hang();
    endtask

    task automatic axi_read(input logic [11:0] idx, input logic [31:0] ed,
                            input logic [1:0] er);
        int   i;
        logic got;
        @(posedge aclk);
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        got = 1'b0;
        for (i = 0; i < 50 && !got; i++)
        begin
            @(posedge aclk);
            got = (s_axi_arready === 1'b1);
        end
        s_axi_arvalid <= 1'b0;
        if (!got)
            hang();
        got = 1'b0;
        for (i = 0; i < 50 && !got; i++)
        begin
            @(posedge aclk);
            if (s_axi_rvalid === 1'b1)
            begin
                got = 1'b1;
                s_axi_rready <= 1'b0;
                `CHK(s_axi_rdata, ed)
                `CHK(s_axi_rresp, er)
            end
        end
        if (!got)
            hang();
    endtask

    // Requests a page and returns once the registered page has settled.
    task automatic tx_send(input logic sel);
        @(posedge aclk);
        tx_np_select <= sel;
        tx_page_req  <= 1'b1;
        @(posedge aclk);
        tx_page_req  <= 1'b0;
        @(negedge aclk);
    endtask

    initial
    begin
        int          k;
        logic [1:0]  seen;
        logic [47:0] p;
        logic [47:0] q;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        tx_page_req  = 1'b0;
        tx_np_select = 1'b0;
        tx_base_page = 48'h0123_4567_89ab;
        tx_np_lower  = 16'hbeef;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (k = 0; k < 6; k++)
            axi_read(IDX_UNP_UPPER + k[11:0], 32'h0000_0000, RESP_OKAY);
        axi_write(IDX_PBP_LOWER, 32'hffff_ffff, 4'hf, RESP_OKAY);
        axi_read(IDX_PBP_LOWER, 32'h0000_0000, RESP_OKAY);
        axi_write(12'h04cc, 32'hffff_ffff, 4'hf, RESP_SLVERR);
        axi_read(12'h04cc, 32'h0000_0000, RESP_SLVERR);
        axi_write(IDX_UNP_UPPER, 32'h1234_5678, 4'hf, RESP_OKAY);
        axi_write(IDX_UNP_UPPER, 32'hffff_ffff, 4'h2, RESP_OKAY);
        axi_read(IDX_UNP_UPPER, 32'h1234_ff78, RESP_OKAY);
        tx_send(1'b1);
        `CHK(tx_page[47:0], {32'h1234_ff78, 16'hbeef})
        `CHK(tx_page[48], 1'b0)
        tx_send(1'b0);
        `CHK(tx_page[47:0], tx_base_page)
        // The upper word stays fixed, so any change in bit 49 has to come from the generator.
        seen = 2'b00;
        for (k = 0; k < 24; k++)
        begin
            tx_send(k[0]);
            if (tx_page[49] === 1'b1)
                seen[1] = 1'b1;
            else if (tx_page[49] === 1'b0)
                seen[0] = 1'b1;
        end
        `CHK(seen, 2'b11)
        for (k = 0; k < 3; k++)
        begin
            p = PATS[k];
            q = ~p;
            rx_m.send_page(1'b0, p);
            @(negedge aclk);
            `CHK({partner_kr_able, partner_kx_able}, {p[23], p[21]})
            axi_read(IDX_PBP_LOWER, {16'h0000, p[15:0]}, RESP_OKAY);
            axi_read(IDX_PBP_UPPER, {2'b00, p[45:16]}, RESP_OKAY);
            axi_read(IDX_PADV, {4'h0, p[13], p[47:46], p[45:21]}, RESP_OKAY);
            rx_m.send_page(1'b1, q);
            axi_read(IDX_PNP_LOWER, {16'h0000, q[15:0]}, RESP_OKAY);
            axi_read(IDX_PNP_UPPER, q[47:16], RESP_OKAY);
            axi_read(IDX_PBP_UPPER, {2'b00, p[45:16]}, RESP_OKAY);
            @(negedge aclk);
            `CHK({partner_kr_able, partner_kx_able}, {p[23], p[21]})
        end
        test_done();
    end
endmodule
